//--- hw/lisir_line_regs.sv
// Purpose: Per-port line interface control, status and latched event registers
// Assumes: Detector levels and the transmit enable pin are asynchronous to clk
// Notes:   Read data appear in the cycle after the read strobe
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ns
`include "lisir_regs.svh"

module lisir_line_regs #(
  parameter int ADDR_W = 16
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Register port
  input  wire logic [ADDR_W-1:0]   addr,
  input  wire logic [7:0]          wrData,
  input  wire logic                wrStrobe,
  input  wire logic                rdStrobe,
  output logic [7:0]               rdData,
  // Asynchronous detector levels
  input  wire logic                rxLossIn,
  input  wire logic                rxShortIn,
  input  wire logic                txShortIn,
  input  wire logic                txOpenIn,
  input  wire logic                eqOverIn,
  input  wire logic                eqUnderIn,
  input  wire logic                jaTripIn,
  input  wire logic [3:0]          rxLevelIn,
  // External transmit enable pin
  input  wire logic                txOutputEnablePin,
  // Analog line controls
  output logic                     txPowerDown,
  output logic                     rxPowerDown,
  output logic                     txLineDriveEn,
  output logic                     rxExtResConnect,
  output logic                     rxIntMatchOn,
  output logic                     rxHighZ,
  output logic [2:0]               rxImpedanceSel,
  output logic                     rxImpReserved,
  // Interrupt request
  output logic                     irq
);

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------

  // Match the port address against one register offset
  function automatic logic addrIs(input logic [ADDR_W-1:0] a, input logic [15:0] ofs);
    addrIs = (a == ADDR_W'(ofs));
  endfunction : addrIs

  wire logic selTxRxCtl  = addrIs(addr, `LISIR_OFS_TX_RX_CTL);
  wire logic selBuildout = addrIs(addr, `LISIR_OFS_BUILDOUT);
  wire logic selMaint    = addrIs(addr, `LISIR_OFS_MAINT_CTL);
  wire logic selStatus   = addrIs(addr, `LISIR_OFS_RT_STATUS);
  wire logic selMask     = addrIs(addr, `LISIR_OFS_IRQ_MASK);
  wire logic selEvents   = addrIs(addr, `LISIR_OFS_EVENTS);
  wire logic selLevel    = addrIs(addr, `LISIR_OFS_RX_LEVEL);
  wire logic selTerm     = addrIs(addr, `LISIR_OFS_RX_TERM);
  wire logic selEqLimit  = addrIs(addr, `LISIR_OFS_EQ_LIMIT);

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------

  localparam int SYNC_W = 12;

  logic [SYNC_W-1:0] syncStage1_reg;
  logic [SYNC_W-1:0] syncStage2_reg;
  wire  logic [SYNC_W-1:0] syncRaw = {txOutputEnablePin, rxLevelIn, jaTripIn, eqUnderIn,
                                      eqOverIn, txOpenIn, txShortIn, rxShortIn, rxLossIn};

  // Two flip-flops on every asynchronous level
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      syncStage1_reg <= '0;
      syncStage2_reg <= '0;
    end else begin
      syncStage1_reg <= syncRaw;
      syncStage2_reg <= syncStage1_reg;
    end
  end

  wire logic       lossNow   = syncStage2_reg[0];
  wire logic       rxShortNow = syncStage2_reg[1];
  wire logic       txShortNow = syncStage2_reg[2];
  wire logic       txOpenNow = syncStage2_reg[3];
  wire logic       eqOverNow = syncStage2_reg[4];
  wire logic       eqUnderNow = syncStage2_reg[5];
  wire logic       jaTripNow = syncStage2_reg[6];
  wire logic [3:0] levelNow  = syncStage2_reg[10:7];
  wire logic       txPinNow  = syncStage2_reg[11];

  // ---------------------------------------------------------------
  // Receive level word
  // ---------------------------------------------------------------

  logic [3:0] levelPrev_reg;
  logic [3:0] levelStable_reg;

  // The four level bits may cross in different cycles; a code is
  // taken only after two equal samples, so no torn word is reported
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      levelPrev_reg   <= 4'h0;
      levelStable_reg <= 4'h0;
    end else begin
      levelPrev_reg <= levelNow;
      if (levelNow == levelPrev_reg) begin
        levelStable_reg <= levelNow;
      end
    end
  end

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------

  lisir_pkg::lisir_byte_t txRxCtl_reg;
  lisir_pkg::lisir_byte_t buildout_reg;
  lisir_pkg::lisir_byte_t maintCtl_reg;
  lisir_pkg::lisir_byte_t irqMask_reg;
  lisir_pkg::lisir_byte_t rxTerm_reg;
  lisir_pkg::lisir_byte_t eqLimit_reg;

  // Software writes; only the implemented bits are stored
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txRxCtl_reg  <= `LISIR_RST_BYTE;
      buildout_reg <= `LISIR_RST_BYTE;
      maintCtl_reg <= `LISIR_RST_BYTE;
      irqMask_reg  <= `LISIR_RST_BYTE;
      rxTerm_reg   <= `LISIR_RST_BYTE;
      eqLimit_reg  <= `LISIR_RST_BYTE;
    end else if (wrStrobe) begin
      if (selTxRxCtl) txRxCtl_reg <= wrData & 8'h42;
      if (selBuildout) buildout_reg <= wrData & 8'h07;
      if (selMaint) maintCtl_reg <= wrData & 8'h07;
      if (selMask) irqMask_reg <= wrData;
      if (selTerm) rxTerm_reg <= wrData & 8'hc7;
      if (selEqLimit) eqLimit_reg <= wrData & 8'h8f;
    end
  end

  // ---------------------------------------------------------------
  // Line control outputs
  // ---------------------------------------------------------------

  wire logic protectMode = txRxCtl_reg[`LISIR_BIT_PROTECT];
  wire logic t1Mode      = txRxCtl_reg[`LISIR_BIT_T1_MODE];
  wire logic rx_ext_res_on      = rxTerm_reg[`LISIR_BIT_REXT_ON];
  wire logic rx_int_match_on      = rxTerm_reg[`LISIR_BIT_RIMP_ON];
  wire logic [2:0] impSel = rxTerm_reg[2:0];
  wire logic protectFloat = protectMode & ~txPinNow;

  // Transmitter power and drive, pin low always floats the outputs
  assign txPowerDown   = maintCtl_reg[`LISIR_BIT_TX_PD];
  assign rxPowerDown   = maintCtl_reg[`LISIR_BIT_RX_PD];
  assign txLineDriveEn = txPinNow & maintCtl_reg[`LISIR_BIT_TX_DRIVE] & ~txPowerDown;

  // Receive termination, protection switching overrides the resistor and match enables but not the impedance select
  assign rxExtResConnect = rx_ext_res_on & ~protectFloat;
  assign rxIntMatchOn    = rx_int_match_on & ~protectFloat;
  assign rxHighZ         = (~rx_ext_res_on & ~rx_int_match_on) | protectFloat;
  assign rxImpedanceSel  = rx_int_match_on ? impSel : {1'b0, impSel[1:0]};
  assign rxImpReserved   = rx_int_match_on & impSel[2];

  // ---------------------------------------------------------------
  // Real-time status and level
  // ---------------------------------------------------------------

  wire lisir_pkg::lisir_byte_t statusNow = {2'b00, eqOverNow, eqUnderNow,
                                            rxShortNow,
                                            txShortNow,
                                            txOpenNow,
                                            lossNow};

  // Short-haul codes are limited to the gain limit code
  wire logic       shortHaul  = eqLimit_reg[`LISIR_BIT_SHORT_HAUL];
  wire logic [3:0] gainLimit  = eqLimit_reg[3:0];
  wire logic [3:0] levelCode  = (shortHaul && levelStable_reg > gainLimit) ? gainLimit :
                                levelStable_reg;
  wire lisir_pkg::lisir_byte_t levelByte = {levelCode, 4'h0};

  // ---------------------------------------------------------------
  // Latched events
  // ---------------------------------------------------------------

  logic [3:0] condPrev_reg;
  lisir_pkg::lisir_byte_t events_reg;
  lisir_pkg::lisir_byte_t events_next;
  wire  logic [3:0] condNow = {jaTripNow, txOpenNow, txShortNow, lossNow};
  wire  logic csuBuildout = t1Mode && (buildout_reg[2:0] >= `LISIR_CSU_FIRST);
  wire  logic [7:0] clearMask = (wrStrobe && selEvents) ? wrData : 8'h00;
  wire  logic [7:0] eventHit;

  // Condition edges set the detect and clear event bits
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_cond
      wire logic rise = condNow[gi] & ~condPrev_reg[gi];
      wire logic fall = ~condNow[gi] & condPrev_reg[gi];
      // Open and short detection is held off in the CSU build-outs
      wire logic gated = csuBuildout &&
                         (gi == int'(lisir_pkg::LISIR_COND_TX_SHORT) ||
                          gi == int'(lisir_pkg::LISIR_COND_TX_OPEN));
      assign eventHit[gi] = rise & ~gated;
      assign eventHit[gi + `LISIR_CLR_BASE] = fall;
    end
  endgenerate

  // Set wins over a write-one clear in the same cycle
  assign events_next = eventHit | (events_reg & ~clearMask);

  // Event bits and the previous condition levels
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      condPrev_reg <= 4'h0;
      events_reg   <= `LISIR_RST_BYTE;
    end else begin
      condPrev_reg <= condNow;
      events_reg   <= events_next;
    end
  end

  // Interrupt while any enabled event is latched
  assign irq = |(events_reg & irqMask_reg);

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------

  // Unmapped offsets read as zero
  wire lisir_pkg::lisir_byte_t rdMux =
    selTxRxCtl  ? txRxCtl_reg  :
    selBuildout ? buildout_reg :
    selMaint    ? maintCtl_reg :
    selStatus   ? statusNow    :
    selMask     ? irqMask_reg  :
    selEvents   ? events_reg   :
    selLevel    ? levelByte    :
    selTerm     ? rxTerm_reg   :
    selEqLimit  ? eqLimit_reg  : 8'h00;

  lisir_pkg::lisir_byte_t rdData_reg;

  // Read data stand in the cycle after the strobe only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdData_reg <= `LISIR_RST_BYTE;
    end else begin
      rdData_reg <= rdStrobe ? rdMux : 8'h00;
    end
  end

  assign rdData = rdData_reg;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------

  property p_tx_pd_float;
    @(posedge clk) disable iff (reset)
      (wrStrobe && selMaint && wrData[`LISIR_BIT_TX_PD]) |=> (txPowerDown && !txLineDriveEn);
  endproperty
  a_tx_pd_float: assert property (p_tx_pd_float) else $error("tx power-down left drive on");

  property p_rx_pd;
    @(posedge clk) disable iff (reset)
      (wrStrobe && selMaint) |=> (rxPowerDown == $past(wrData[`LISIR_BIT_RX_PD]));
  endproperty
  a_rx_pd: assert property (p_rx_pd) else $error("rx power-down not taken");

  property p_pin_override;
    @(posedge clk) disable iff (reset)
      !txOutputEnablePin [*3] |-> !txLineDriveEn;
  endproperty
  a_pin_override: assert property (p_pin_override) else $error("pin low but tx driven");

  property p_status_read;
    @(posedge clk) disable iff (reset)
      (rdStrobe && selStatus) |=> (rdData[3:0] == $past({rxShortIn, txShortIn, txOpenIn,
                                                        rxLossIn}, 3));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read mismatch");

  property p_loss_set;
    @(posedge clk) disable iff (reset)
      $rose(lossNow) |=> events_reg[0] [*1];
  endproperty
  a_loss_set: assert property (p_loss_set) else $error("loss detect not latched");

  property p_loss_clear;
    @(posedge clk) disable iff (reset)
      $fell(lossNow) |=> events_reg[`LISIR_CLR_BASE];
  endproperty
  a_loss_clear: assert property (p_loss_clear) else $error("loss clear not latched");

  property p_sticky;
    @(posedge clk) disable iff (reset)
      (events_reg[7] && !(wrStrobe && selEvents && wrData[7])) |=> events_reg[7];
  endproperty
  a_sticky: assert property (p_sticky) else $error("event bit dropped");

  property p_w1c;
    @(posedge clk) disable iff (reset)
      (wrStrobe && selEvents && wrData[1] && !eventHit[1]) |=> !events_reg[1];
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");

  property p_mask_irq;
    @(posedge clk) disable iff (reset)
      (wrStrobe && selMask && (wrData & events_reg) != 8'h00 && clearMask == 8'h00) |=> irq;
  endproperty
  a_mask_irq: assert property (p_mask_irq) else $error("enabled event gave no irq");

  property p_level_limit;
    @(posedge clk) disable iff (reset)
      (rdStrobe && selLevel && shortHaul) |=> (rdData[7:4] <= $past(gainLimit));
  endproperty
  a_level_limit: assert property (p_level_limit) else $error("level above gain limit");

  property p_protect;
    @(posedge clk) disable iff (reset)
      (protectMode && !txPinNow) |-> (rxHighZ && !rxIntMatchOn && !rxExtResConnect);
  endproperty
  a_protect: assert property (p_protect) else $error("protection float missing");

  property p_csu_quiet;
    @(posedge clk) disable iff (reset)
      (csuBuildout && !events_reg[2] && !events_reg[1]) |=> (!events_reg[2] && !events_reg[1]);
  endproperty
  a_csu_quiet: assert property (p_csu_quiet) else $error("detect event in CSU build-out");

  property p_level_plain;
    @(posedge clk) disable iff (reset)
      (rdStrobe && selLevel && !shortHaul) |=> (rdData == {$past(levelStable_reg), 4'h0});
  endproperty
  a_level_plain: assert property (p_level_plain) else $error("level code read mismatch");

  property p_rx_match;
    @(posedge clk) disable iff (reset)
      !protectFloat |-> (rxIntMatchOn == rx_int_match_on && rxExtResConnect == rx_ext_res_on);
  endproperty
  a_rx_match: assert property (p_rx_match) else $error("termination not from select");

  property p_drive_bit;
    @(posedge clk) disable iff (reset)
      (txPinNow && !txPowerDown) |-> (txLineDriveEn == maintCtl_reg[`LISIR_BIT_TX_DRIVE]);
  endproperty
  a_drive_bit: assert property (p_drive_bit) else $error("drive bit not followed");

  property p_irq_off;
    @(posedge clk) disable iff (reset)
      ((events_reg & irqMask_reg) == 8'h00) |-> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without enabled event");

endmodule : lisir_line_regs

//--- hw/lisir_regs.svh
// Purpose: Register offsets, field positions and reset values of the line status bank
// Assumes: Byte-wide registers at their printed port-relative offsets
// Notes:   Definitions only
`ifndef LISIR_REGS_SVH
`define LISIR_REGS_SVH

// ---------------------------------------------------------------
// Offsets
// ---------------------------------------------------------------
`define LISIR_OFS_TX_RX_CTL     16'h1000
`define LISIR_OFS_BUILDOUT      16'h1001
`define LISIR_OFS_MAINT_CTL     16'h1002
`define LISIR_OFS_RT_STATUS     16'h1003
`define LISIR_OFS_IRQ_MASK      16'h1004
`define LISIR_OFS_EVENTS        16'h1005
`define LISIR_OFS_RX_LEVEL      16'h1006
`define LISIR_OFS_RX_TERM       16'h1007
`define LISIR_OFS_EQ_LIMIT      16'h1009

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LISIR_BIT_TX_PD         2
`define LISIR_BIT_RX_PD         1
`define LISIR_BIT_TX_DRIVE      0
`define LISIR_BIT_PROTECT       6
`define LISIR_BIT_T1_MODE       1
`define LISIR_BIT_REXT_ON       7
`define LISIR_BIT_RIMP_ON       6
`define LISIR_BIT_SHORT_HAUL    7
`define LISIR_LEVEL_LSB         4
`define LISIR_CLR_BASE          4
`define LISIR_CSU_FIRST         3'h5

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define LISIR_RST_BYTE          8'h00

`endif

//--- hw/lisir_pkg.sv
// Purpose: Types shared by the line status register bank
// Assumes: Byte-wide register data
// Notes:   Types only; constants live in lisir_regs.svh
package lisir_pkg;

  // Register data byte
  typedef logic [7:0] lisir_byte_t;

  // Line conditions watched for events, in event bit order
  typedef enum logic [1:0] {
    LISIR_COND_LOSS,
    LISIR_COND_TX_SHORT,
    LISIR_COND_TX_OPEN,
    LISIR_COND_JA_TRIP
  } lisir_cond_t;

endpackage : lisir_pkg

//--- bench/lisir_line_regs_bench.sv
// Purpose: Self-checking bench for the line status register bank
// Assumes: Read data stand only in the cycle after the read strobe
// Notes:   Reads queue their expected byte; a monitor pops and compares
`timescale 1ns/1ns
`include "lisir_regs.svh"
module lisir_line_regs_bench;
  // Expected read result
  typedef struct {
    string       name;
    logic [7:0]  val;
  } lisir_exp_t;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk, reset, wrStrobe, rdStrobe, jaTrip, pin, rdPend;
  logic [15:0] addr;
  logic [7:0]  wrData, rdData, d;
  logic [5:0]  det;
  logic [3:0]  lvl, lim;
  logic        txPowerDown, rxPowerDown, txLineDriveEn, rxExtResConnect;
  logic        rxIntMatchOn, rxHighZ, rxImpReserved, irq, prot;
  logic [2:0]  rxImpedanceSel;
  int          err_total, total_checks;
  lisir_exp_t  expQ[$];

  lisir_line_regs DUT (
    .clk(clk), .reset(reset), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .rdData(rdData), .rxLossIn(det[0]), .rxShortIn(det[3]),
    .txShortIn(det[2]), .txOpenIn(det[1]), .eqOverIn(det[5]), .eqUnderIn(det[4]),
    .jaTripIn(jaTrip), .rxLevelIn(lvl), .txOutputEnablePin(pin),
    .txPowerDown(txPowerDown), .rxPowerDown(rxPowerDown), .txLineDriveEn(txLineDriveEn),
    .rxExtResConnect(rxExtResConnect), .rxIntMatchOn(rxIntMatchOn), .rxHighZ(rxHighZ),
    .rxImpedanceSel(rxImpedanceSel), .rxImpReserved(rxImpReserved), .irq(irq));

  // Clock at 20 MHz
  initial clk = 1'b0;
  always #25 clk = ~clk;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic end_sim;
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk);
    addr     <= a;
    wrData   <= v;
    wrStrobe <= 1'b1;
    @(posedge clk);
    wrStrobe <= 1'b0;
  endtask : wr

  task automatic rd(input string n, input logic [15:0] a, input logic [7:0] e);
    lisir_exp_t x;
    x.name = n;
    x.val  = e;
    @(posedge clk);
    addr     <= a;
    rdStrobe <= 1'b1;
    expQ.push_back(x);
    @(posedge clk);
    rdStrobe <= 1'b0;
  endtask : rd

  // Detectors pass two sync flops; six cycles covers them
  task automatic settle;
    repeat (6) @(posedge clk);
  endtask : settle

  // Event condition index to detector input
  task automatic cond(input int c, input logic v);
    case (c)
      0: det[0] <= v;
      1: det[2] <= v;
      2: det[1] <= v;
      default: jaTrip <= v;
    endcase
  endtask : cond

  // ---------------------------------------------------------------
  // Read monitor
  // ---------------------------------------------------------------
  // Marks the cycle in which read data stand
  always @(posedge clk) rdPend <= rdStrobe & ~reset;

  // Pops the oldest expectation when read data appear
  always @(negedge clk) begin
    lisir_exp_t x;
    if (rdPend) begin
      if (expQ.size() == 0) begin
        err_total++;
        $display("CHECK FAILED read queue expected entry seen none");
      end else begin
        x = expQ.pop_front();
        chk(x.name, x.val, rdData);
      end
    end
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_sim();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {reset, wrStrobe, rdStrobe, jaTrip, pin} = 5'b10000;
    addr = 16'h0000; wrData = 8'h00; det = 6'h00; lvl = 4'h0;
    err_total = 0; total_checks = 0;
    void'($urandom(47));
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    // Reset values and idle outputs
    rd("status", `LISIR_OFS_RT_STATUS, 8'h00);
    rd("mask", `LISIR_OFS_IRQ_MASK, 8'h00);
    rd("events", `LISIR_OFS_EVENTS, 8'h00);
    rd("term", `LISIR_OFS_RX_TERM, 8'h00);
    chk("rxHighZ", 8'h01, {7'h0, rxHighZ});
    chk("irq", 8'h00, {7'h0, irq});
    // Register access, read-only and unmapped places
    d = 8'($urandom);
    wr(`LISIR_OFS_IRQ_MASK, d);
    rd("mask", `LISIR_OFS_IRQ_MASK, d);
    wr(`LISIR_OFS_RT_STATUS, 8'hff);
    rd("status", `LISIR_OFS_RT_STATUS, 8'h00);
    wr(16'h1010, 8'hff);
    rd("unmapped", 16'h1010, 8'h00);
    // Transmit and receive power and drive controls
    for (int i = 0; i < 16; i++) begin
      wr(`LISIR_OFS_MAINT_CTL, {5'h0, i[2:0]});
      pin <= i[3];
      settle();
      chk("txPowerDown", {7'h0, i[2]}, {7'h0, txPowerDown});
      chk("rxPowerDown", {7'h0, i[1]}, {7'h0, rxPowerDown});
      chk("txDrive", {7'h0, i[3] & i[0] & ~i[2]}, {7'h0, txLineDriveEn});
    end
    // Real-time status bits, one at a time
    for (int b = 0; b < 6; b++) begin
      det <= 6'(1 << b);
      settle();
      rd("status", `LISIR_OFS_RT_STATUS, 8'(1 << b));
    end
    det <= 6'h00;
    jaTrip <= 1'b0;
    settle();
    wr(`LISIR_OFS_EVENTS, 8'hff);
    rd("events", `LISIR_OFS_EVENTS, 8'h00);
    // Set and clear events, masks, write-one clear
    for (int c = 0; c < 4; c++) begin
      wr(`LISIR_OFS_IRQ_MASK, 8'(1 << c));
      cond(c, 1'b1);
      settle();
      rd("eventSet", `LISIR_OFS_EVENTS, 8'(1 << c));
      chk("irq", 8'h01, {7'h0, irq});
      cond(c, 1'b0);
      settle();
      rd("eventClr", `LISIR_OFS_EVENTS, 8'((1 << c) | (16 << c)));
      wr(`LISIR_OFS_EVENTS, 8'h00);
      rd("eventKeep", `LISIR_OFS_EVENTS, 8'((1 << c) | (16 << c)));
      wr(`LISIR_OFS_EVENTS, 8'(1 << c));
      rd("eventW1c", `LISIR_OFS_EVENTS, 8'(16 << c));
      chk("irq", 8'h00, {7'h0, irq});
      wr(`LISIR_OFS_IRQ_MASK, 8'(16 << c));
      @(negedge clk);
      chk("irqClr", 8'h01, {7'h0, irq});
      wr(`LISIR_OFS_EVENTS, 8'hff);
    end
    // Open and short detect stay quiet in CSU build-outs
    wr(`LISIR_OFS_TX_RX_CTL, 8'h02);
    for (int l = 5; l < 8; l++) begin
      wr(`LISIR_OFS_BUILDOUT, 8'(l));
      det <= 6'h06;
      settle();
      rd("csuEvents", `LISIR_OFS_EVENTS, 8'h00);
      det <= 6'h00;
      settle();
      wr(`LISIR_OFS_EVENTS, 8'hff);
    end
    // Receive level, plain and limited in short haul
    for (int i = 0; i < 6; i++) begin
      lvl <= 4'($urandom);
      lim = 4'($urandom);
      wr(`LISIR_OFS_EQ_LIMIT, (i > 2) ? {4'h8, lim} : 8'h00);
      settle();
      if (i > 2 && lvl > lim)
        rd("levelLim", `LISIR_OFS_RX_LEVEL, {lim, 4'h0});
      else
        rd("level", `LISIR_OFS_RX_LEVEL, {lvl, 4'h0});
    end
    // Receive termination, impedance and protection float
    for (int i = 0; i < 16; i++) begin
      d = 8'($urandom);
      prot = i[0];
      wr(`LISIR_OFS_TX_RX_CTL, {1'b0, prot, 6'h00});
      wr(`LISIR_OFS_RX_TERM, d);
      pin <= i[1];
      settle();
      rd("term", `LISIR_OFS_RX_TERM, d & 8'hc7);
      chk("extRes", {7'h0, d[7] & ~(prot & ~i[1])}, {7'h0, rxExtResConnect});
      chk("intMatch", {7'h0, d[6] & ~(prot & ~i[1])}, {7'h0, rxIntMatchOn});
      chk("highZ", {7'h0, (~d[7] & ~d[6]) | (prot & ~i[1])}, {7'h0, rxHighZ});
      chk("impSel", {5'h0, d[6] ? d[2:0] : {1'b0, d[1:0]}}, {5'h0, rxImpedanceSel});
      chk("impRes", {7'h0, d[6] & d[2]}, {7'h0, rxImpReserved});
    end
    // Drain outstanding reads
    for (int k = 0; k < 10 && expQ.size() > 0; k++) @(posedge clk);
    if (expQ.size() > 0) begin
      err_total++;
      $display("CHECK FAILED read queue expected empty seen %0d", expQ.size());
    end
    end_sim();
  end
endmodule : lisir_line_regs_bench
